//--- logic/adc_seq_defs.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * converter sequencer. Assumes a 10 MHz system clock and a 32-bit Wishbone bus.
 */
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH

`define ADC_CLK_HZ 10000000
// Result registers, one high/low word pair per input
`define ADC_RES_HI_BASE 8'h00
`define ADC_RES_LO_BASE 8'h20
`define ADC_CTRL_OFF 8'h40
`define ADC_EXT_OFF 8'h44
`define ADC_IRQ_STAT_OFF 8'h48
`define ADC_IRQ_CLR_OFF 8'h4C
`define ADC_IRQ_EN_OFF 8'h50
// Control/status layout
`define ADC_CTRL_FLAG_BIT 7
`define ADC_CTRL_IE_BIT 6
`define ADC_CTRL_START_BIT 5
`define ADC_CTRL_SCAN_BIT 4
`define ADC_CTRL_CKS_BIT 3
`define ADC_CTRL_GRP_BIT 2
`define ADC_CTRL_SEL_HI 1
`define ADC_CTRL_SEL_LO 0
`define ADC_CTRL_RESET 8'h00
`define ADC_EXT_EN_BIT 7
`define ADC_EXT_RESET 8'h7F
// Conversion times in states
`define ADC_SLOW_STATES 266
`define ADC_FAST_STATES 134

`endif

//--- logic/adc_seq_pkg.sv
/*
 * Types of the converter sequencer.
 * Assumes nothing beyond a SystemVerilog tool.
 */
package adc_seq_pkg;
	typedef enum logic [1:0] {
		seq_idle,
		seq_convert,
		seq_next
	} seq_state_e;
	typedef logic [9:0] sample_t;
endpackage : adc_seq_pkg

//--- logic/adc_sequencer_control.sv
/*
 * Control, sequencing and result storage of an eight-input 10-bit converter
 * with a classic Wishbone slave. Assumes the analog front end presents a
 * sample for the addressed input on sample_i and an external start pin that
 * is synchronous to clk_i.
 */
// The implementer's own choices: the placing of the registers and register access over Wishbone.
//
// Function
// - Each result is a 10-bit value read as a high byte and a low byte.
// - A three-bit field selects the group and either one input or the sweep length.
// - Clock select picks a conversion time of 266 or 134 states per input.
// - In single mode the start bit runs one conversion and then clears itself.
// - In scan mode the selected inputs are swept repeatedly until start is written 0.
// - With start at 0 nothing converts, and writing 0 halts a conversion.
// - In single mode the done flag sets when the conversion completes.
// - In scan mode the done flag sets after each full sweep.
// - The done flag clears only by a write of 0 after it was read as 1.
// - Writing 1 to the done flag never sets it.
// - The interrupt-enable bit gates the done interrupt.
// - With trigger enable set the external pin also starts conversion; else it is ignored.
// - Trigger enable sits at bit 7, resets to 0, the other bits read 1.
`timescale 1ns/1ps
`include "adc_seq_defs.svh"

module adc_sequencer_control
	import adc_seq_pkg::*;
#(
	parameter int SLOW_STATES = `ADC_SLOW_STATES,
	parameter int FAST_STATES = `ADC_FAST_STATES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic ext_start_pin_i,
	input wire logic [9:0] sample_i,
	output logic [2:0] sense_input_sel_o,
	output logic sample_strobe_o,
	output logic conversion_done_irq_o,
	output logic irq_o
);

	// State per conversion counts system clocks, one state per clock
	localparam logic [8:0] SLOW_LAST = 9'(SLOW_STATES - 1);
	localparam logic [8:0] FAST_LAST = 9'(FAST_STATES - 1);

	seq_state_e state_r;
	logic [7:0] ctrl_r;
	logic ext_en_r;
	logic flag_seen_r;
	logic [8:0] cnt_r;
	logic [2:0] cur_r;
	logic ext_pin_d_r;
	logic ext_event;
	sample_t result_r [8];
	logic [1:0] irq_stat_r;
	logic [1:0] irq_en_r;

	logic req;
	logic wr;
	logic rd;
	logic conv_end;
	logic sweep_end;
	logic start_cleared;
	logic [2:0] first_in;
	logic [2:0] last_in;
	// Sticky status terms, split out so the set/clear priority reads plainly
	logic [1:0] irq_clr;
	logic [1:0] irq_set;
	logic store_ok;

	function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
		hit = (adr[7:2] == off[7:2]);
	endfunction : hit

	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr = req && wb_we_i && wb_sel_i[0];
	assign rd = req && !wb_we_i;

	// Group start and the last input of the sweep or the single input
	assign first_in = {ctrl_r[`ADC_CTRL_GRP_BIT], 2'b00};
	assign last_in = {ctrl_r[`ADC_CTRL_GRP_BIT], ctrl_r[`ADC_CTRL_SEL_HI:`ADC_CTRL_SEL_LO]};

	// Rising edge of the external pin counts only when enabled
	assign ext_event = ext_en_r && ext_start_pin_i && !ext_pin_d_r;

	assign conv_end = (state_r == seq_convert) && ctrl_r[`ADC_CTRL_START_BIT] &&
		(cnt_r == (ctrl_r[`ADC_CTRL_CKS_BIT] ? FAST_LAST : SLOW_LAST));
	assign sweep_end = conv_end && (cur_r == last_in);
	assign start_cleared = wr && hit(wb_adr_i, `ADC_CTRL_OFF) &&
		!wb_dat_i[`ADC_CTRL_START_BIT];

	// An abort in the final cycle still stores the result, but no event is reported for it
	assign store_ok = !start_cleared;

	// Clear mask from a write to the clear register; events set bits in the same cycle
	assign irq_clr = (wr && hit(wb_adr_i, `ADC_IRQ_CLR_OFF)) ? wb_dat_i[1:0] : 2'h0;
	assign irq_set = {sweep_end && store_ok, conv_end && store_ok};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_pin_d_r <= 1'b0;
		end else begin
			ext_pin_d_r <= ext_start_pin_i;
		end
	end

	// Sequencer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= seq_idle;
			cnt_r <= 9'h000;
			cur_r <= 3'h0;
		end else begin
			case (state_r)
				seq_idle: begin
					cnt_r <= 9'h000;
					if (ctrl_r[`ADC_CTRL_START_BIT]) begin
						state_r <= seq_convert;
						cur_r <= ctrl_r[`ADC_CTRL_SCAN_BIT] ? first_in : last_in;
					end
				end
				seq_convert: begin
					if (!ctrl_r[`ADC_CTRL_START_BIT]) begin
						state_r <= seq_idle;
					end else if (conv_end) begin
						state_r <= seq_next;
					end else begin
						cnt_r <= cnt_r + 9'h001;
					end
				end
				seq_next: begin
					cnt_r <= 9'h000;
					if (!ctrl_r[`ADC_CTRL_START_BIT]) begin
						state_r <= seq_idle;
					end else begin
						// Scan wraps to the group start after the last input
						state_r <= seq_convert;
						cur_r <= (cur_r == last_in) ? first_in : cur_r + 3'h1;
					end
				end
				default: begin
					state_r <= seq_idle;
				end
			endcase
		end
	end

	// Result store, one register per input; each loads only at the end of its own
	// conversion, so software may read any other input while a sweep runs
	generate
		for (genvar g = 0; g < 8; g++) begin : g_result
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					result_r[g] <= 10'h000;
				end else if (conv_end && (cur_r == 3'(g))) begin
					result_r[g] <= sample_i;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sense_input_sel_o <= 3'h0;
			sample_strobe_o <= 1'b0;
		end else begin
			sense_input_sel_o <= cur_r;
			sample_strobe_o <= conv_end && !start_cleared;
		end
	end

	// Control/status register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_r <= `ADC_CTRL_RESET;
			flag_seen_r <= 1'b0;
		end else begin
			if (wr && hit(wb_adr_i, `ADC_CTRL_OFF)) begin
				ctrl_r[6:0] <= wb_dat_i[6:0];
			end
			// Hardware start: enabled external pin edge, in any state
			if (ext_event) begin
				ctrl_r[`ADC_CTRL_START_BIT] <= 1'b1;
			end
			if (sweep_end && !ctrl_r[`ADC_CTRL_SCAN_BIT] && !start_cleared) begin
				ctrl_r[`ADC_CTRL_START_BIT] <= 1'b0;
			end
			if (rd && hit(wb_adr_i, `ADC_CTRL_OFF) && ctrl_r[`ADC_CTRL_FLAG_BIT]) begin
				flag_seen_r <= 1'b1;
			end
			// Clear only after a read of 1; a written 1 is ignored
			if (wr && hit(wb_adr_i, `ADC_CTRL_OFF) && !wb_dat_i[`ADC_CTRL_FLAG_BIT] &&
				flag_seen_r) begin
				ctrl_r[`ADC_CTRL_FLAG_BIT] <= 1'b0;
				flag_seen_r <= 1'b0;
			end
			// Setting wins over a clear in the same cycle
			if (sweep_end && !start_cleared) begin
				ctrl_r[`ADC_CTRL_FLAG_BIT] <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_en_r <= 1'b0;
		end else if (wr && hit(wb_adr_i, `ADC_EXT_OFF)) begin
			ext_en_r <= wb_dat_i[`ADC_EXT_EN_BIT];
		end
	end

	// Sticky status: bit 0 conversion end, bit 1 sweep end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat_r <= 2'h0;
			irq_en_r <= 2'h0;
		end else begin
			if (wr && hit(wb_adr_i, `ADC_IRQ_EN_OFF)) begin
				irq_en_r <= wb_dat_i[1:0];
			end
			// Set wins over clear when both fall in one cycle
			irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			conversion_done_irq_o <= 1'b0;
			irq_o <= 1'b0;
		end else begin
			// Registered one cycle behind flag and enable
			conversion_done_irq_o <= ctrl_r[`ADC_CTRL_FLAG_BIT] &&
				ctrl_r[`ADC_CTRL_IE_BIT];
			irq_o <= |(irq_stat_r & irq_en_r);
		end
	end

	// Wishbone answer: ack one cycle after the request, dropped the next
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= 32'h0000_0000;
			if (rd) begin
				if (wb_adr_i < `ADC_RES_LO_BASE) begin
					wb_dat_o <= {30'h0, result_r[wb_adr_i[4:2]][9:8]};
				end else if (wb_adr_i < `ADC_CTRL_OFF) begin
					wb_dat_o <= {24'h0, result_r[wb_adr_i[4:2]][7:0]};
				end else if (hit(wb_adr_i, `ADC_CTRL_OFF)) begin
					wb_dat_o <= {24'h0, ctrl_r};
				end else if (hit(wb_adr_i, `ADC_EXT_OFF)) begin
					wb_dat_o <= {24'h0, ext_en_r, 7'h7F};
				end else if (hit(wb_adr_i, `ADC_IRQ_STAT_OFF)) begin
					wb_dat_o <= {30'h0, irq_stat_r};
				end else if (hit(wb_adr_i, `ADC_IRQ_EN_OFF)) begin
					wb_dat_o <= {30'h0, irq_en_r};
				end
			end
		end
	end

endmodule : adc_sequencer_control

//--- sim/adc_front_model.sv
/* Front-end stand-in: an analog value per input and the external start pin.
   Assumes clk_i is the block clock. */
`timescale 1ns/1ps
module adc_front_model (
	input wire logic clk_i,
	input wire logic [2:0] sel_i,
	output logic [9:0] sample_o,
	output logic pin_o
);
	// Upper bits name the input so a mix-up shows in the result
	assign sample_o = {sel_i, 7'h4B};
	initial pin_o = 1'h0;
	task automatic pulse;
		@(posedge clk_i);
		pin_o <= 1'h1;
		@(posedge clk_i);
		pin_o <= 1'h0;
	endtask : pulse
endmodule : adc_front_model

//--- sim/adc_sequencer_control_asserts.sv
/* Port checker of the converter sequencer.
   Assumes a master that holds each request until ack. */
`timescale 1ns/1ps
module adc_sequencer_control_asserts #(
	parameter int SLOW_STATES = 266,
	parameter int FAST_STATES = 134
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic sample_strobe_o,
	input wire logic conversion_done_irq_o
);
	// Slack covers start latency and the registered strobe
	localparam int F_LO = FAST_STATES - 1;
	localparam int F_HI = FAST_STATES + 4;
	localparam int S_LO = SLOW_STATES - 1;
	localparam int S_HI = SLOW_STATES + 4;
	logic cw;
	assign cw = wb_ack_o & wb_we_i & wb_sel_i[0] & (wb_adr_i == 8'h40);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held");
	a_strobe_once: assert property (sample_strobe_o |=> !sample_strobe_o)
		else $error("strobe held");
	a_halt_quiet: assert property (cw && !wb_dat_i[5] |-> ##2 !sample_strobe_o [*6])
		else $error("result after halt");
	a_fast_time: assert property (cw && wb_dat_i[5] && wb_dat_i[3] |-> ##[F_LO:F_HI] sample_strobe_o)
		else $error("fast time off");
	a_slow_time: assert property (cw && wb_dat_i[5] && !wb_dat_i[3] |-> ##[S_LO:S_HI] sample_strobe_o)
		else $error("slow time off");
	a_irq_masked: assert property (cw && !wb_dat_i[6] |-> ##2 !conversion_done_irq_o)
		else $error("irq not masked");
	a_ext_reserved: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h44 |-> wb_dat_o[6:0] == 7'h7F)
		else $error("reserved bits");
endmodule : adc_sequencer_control_asserts
bind adc_sequencer_control adc_sequencer_control_asserts #(.SLOW_STATES(SLOW_STATES),
	.FAST_STATES(FAST_STATES)) chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
	.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .sample_strobe_o, .conversion_done_irq_o);

//--- sim/adc_sequencer_control_bench.sv
/* Self-checking bench of the converter sequencer.
   Assumes the front-end model and the bound checker. */
`timescale 1ns/1ps
module adc_sequencer_control_bench;
	logic clk_i = 1'h0;
	logic rst_i = 1'h1;
	logic cyc = 1'h0;
	logic stb = 1'h0;
	logic we = 1'h0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0;
	logic [31:0] rdat, q;
	logic ack, strb, dirq, irq, pin;
	logic [2:0] sel_o;
	logic [9:0] smp;
	int error_cnt = 0;
	int tests_run = 0;
	int c;
	logic [7:0] ra [5] = '{8'h44, 8'h40, 8'h48, 8'h60, 8'h00};
	logic [31:0] rv [5] = '{32'h7F, 32'h0, 32'h0, 32'h0, 32'h0};
	// Short conversions keep the run brief; they still differ so speed shows
	adc_sequencer_control #(.SLOW_STATES(12), .FAST_STATES(6)) dut (.clk_i, .rst_i,
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
		.wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .ext_start_pin_i(pin),
		.sample_i(smp), .sense_input_sel_o(sel_o), .sample_strobe_o(strb),
		.conversion_done_irq_o(dirq), .irq_o(irq));
	adc_front_model fm (.clk_i, .sel_i(sel_o), .sample_o(smp), .pin_o(pin));
	initial forever #50 clk_i = ~clk_i;
	task automatic final_report;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : final_report
	task automatic chk(input logic [31:0] e, input logic [31:0] g, input string n);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		dat <= d;
		do @(posedge clk_i); while (ack !== 1'h1);
		q = rdat;
		cyc <= 1'h0;
		stb <= 1'h0;
	endtask : wb
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
		wb(1'h0, a, 32'h0);
		chk(e, q, n);
	endtask : rd
	task automatic wstb(input int n);
		c = 0;
		repeat (n) begin
			@(posedge clk_i);
			c += (strb === 1'h1);
		end
	endtask : wstb
	task automatic pause;
		repeat (3) @(posedge clk_i);
	endtask : pause
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'h0;
		foreach (ra[i]) rd(ra[i], rv[i], "reset value");
		wb(1'h1, 8'h40, 32'h80);
		rd(8'h40, 32'h0, "flag by write");
		$display("reset test done");
		wb(1'h1, 8'h40, 32'h6D);
		pause();
		chk(32'h5, sel_o, "input");
		wstb(40);
		chk(32'h1, c, "single count");
		chk(32'h1, dirq, "done irq");
		rd(8'h40, 32'hCD, "single ctrl");
		rd(8'h14, 32'h2, "result high");
		rd(8'h34, 32'hCB, "result low");
		wb(1'h1, 8'h40, 32'h4D);
		pause();
		chk(32'h0, dirq, "flag cleared");
		wb(1'h1, 8'h50, 32'h2);
		pause();
		chk(32'h1, irq, "irq raised");
		wb(1'h1, 8'h50, 32'h0);
		pause();
		chk(32'h0, irq, "irq masked");
		wb(1'h1, 8'h4C, 32'h3);
		rd(8'h48, 32'h0, "irq status");
		$display("single test done");
		wb(1'h1, 8'h40, 32'h31);
		wstb(120);
		chk(32'h1, c >= 3, "scan repeats");
		rd(8'h40, 32'hB1, "sweep ctrl");
		chk(32'h0, dirq, "ie off irq");
		wb(1'h1, 8'h40, 32'h0);
		wstb(40);
		chk(32'h0, c, "halted");
		rd(8'h40, 32'h0, "halt ctrl");
		$display("scan test done");
		wb(1'h1, 8'h44, 32'h80);
		rd(8'h44, 32'hFF, "trig enable");
		wb(1'h1, 8'h40, 32'h08);
		fm.pulse();
		wstb(40);
		chk(32'h1, c, "pin start");
		rd(8'h40, 32'h88, "pin ctrl");
		wb(1'h1, 8'h44, 32'h0);
		wb(1'h1, 8'h40, 32'h08);
		fm.pulse();
		wstb(40);
		chk(32'h0, c, "pin ignored");
		$display("trigger test done");
		final_report();
	end
	initial begin
		#400000;
		error_cnt++;
		final_report();
	end
endmodule : adc_sequencer_control_bench
